// File: src/lamp_pwm_cfg.svh
// Contract
// - clock failure forces outputs to full duty
// - each channel holds its own 8-bit duty
// - bits D10:D9 select channel phase
// - bit D8 switches channel, rising starts window
// - on bits mirrored in output control register
// - full-on, off, phase, divider apply immediately
// - duty below full applies next period
// - duty changes from write, select, or step
// - sync bit D1 resets all PWM counters
// - divider select 00 /4, 01 /2, 1x /1
// - 256 duty steps per period from CLK
// - no PWM in fail mode or clock failure
// - select bit picks own or shared duty
// - shared duty held in own register
// - channel state follows pin mode table
// - shared duty keeps channel phase and divider
// - step command moves five power channels only
// - one direction bit: 0 down, 1 up
// - step code: none, 4, 8, 16
// - stepping saturates at 00 and FF
`ifndef LAMP_PWM_CFG_SVH
`define LAMP_PWM_CFG_SVH
`define ADDR_INIT2 4'h1
`define ADDR_CH_FIRST 4'h2
`define ADDR_CH_LAST 4'h7
`define ADDR_OUT_CTRL 4'h8
`define ADDR_GLOBAL 4'h9
`define ADDR_PIN_MODE 4'hb
`define ADDR_DIVIDER 4'hc
`define ADDR_STEP 4'he
`define BIT_SYNC 1
`define BIT_SUBREG 8
`define BIT_ON 8
`define BIT_STEP_DIR 10
`define DUTY_FULL 8'hff
`define DUTY_EMPTY 8'h00
`define PHASE_SHIFT 6
`endif

// File: src/lamp_pwm_pkg.sv
package lamp_pwm_pkg;
    typedef logic [7:0] duty_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } reg_wr_t;
endpackage : lamp_pwm_pkg

// File: src/lamp_pwm_ctrl.sv
`timescale 1ns/1ps
`include "lamp_pwm_cfg.svh"
module lamp_pwm_ctrl #(
    parameter int NCH = 6
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic reg_wr, // pulse at chip-select rising edge
    input wire lamp_pwm_pkg::reg_wr_t reg_in, // frame address and data
    input wire logic timing_clk, // pwm timing clock, sampled
    input wire logic clk_fail, // timing clock judged failed
    input wire logic fail_mode, // device in fail mode
    input wire logic [3:0] control_input_pin, // deglitched control inputs
    output logic [NCH-1:0] channel_drive_ff, // output drive
    output logic [NCH-1:0] window_start_ff, // overcurrent window start pulse
    output logic [NCH-1:0] channel_state // channel state
);
    ////////////////////////////////////////////////////////////////////////////
    logic [NCH-1:0] on_ff, shared_duty_select_ff, run_ff, state_q_ff;
    logic [1:0] phase_select_ff [NCH];
    logic [1:0] divider_select_ff [NCH];
    logic [1:0] pin_mode_ff [4];
    lamp_pwm_pkg::duty_t duty_value_ff [NCH];
    lamp_pwm_pkg::duty_t act_duty_ff [NCH];
    lamp_pwm_pkg::duty_t shared_duty_ff;
    logic [9:0] cnt_ff;
    logic tclk_q_ff, step_ff;
    logic [NCH-1:0] pstart, lit;
    lamp_pwm_pkg::duty_t tgt [NCH];
    lamp_pwm_pkg::duty_t pos [NCH];
    logic [NCH-1:0] nxt_drive;
    logic wr_ch, wr_sync, wr_step;

    assign wr_ch = reg_wr && reg_in.addr >= `ADDR_CH_FIRST && reg_in.addr <= `ADDR_CH_LAST;
    assign wr_sync = reg_wr && reg_in.addr == `ADDR_INIT2 && reg_in.data[`BIT_SYNC];
    assign wr_step = reg_wr && reg_in.addr == `ADDR_STEP;

    ////////////////////////////////////////////////////////////////////////////
    function automatic lamp_pwm_pkg::duty_t step_duty(input lamp_pwm_pkg::duty_t d,
            input logic [1:0] code, input logic up);
        logic [8:0] amt;
        logic [8:0] sum;
        amt = (code == 2'h0) ? 9'h000 : (9'h002 << code);
        sum = up ? ({1'b0, d} + amt) : ({1'b0, d} - amt);
        if (up && sum[8]) begin
            return `DUTY_FULL;
        end else if (!up && sum[8]) begin
            return `DUTY_EMPTY;
        end
        return sum[7:0];
    endfunction : step_duty

    function automatic lamp_pwm_pkg::duty_t ch_pos(input logic [9:0] c,
            input logic [1:0] prs, input logic [1:0] ph);
        lamp_pwm_pkg::duty_t b;
        b = prs[1] ? c[7:0] : (prs[0] ? c[8:1] : c[9:2]);
        return b - {ph, 6'h00};
    endfunction : ch_pos

    ////////////////////////////////////////////////////////////////////////////
    // timing clock counter; slow bands use the upper counter bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tclk_q_ff <= 1'b0;
            cnt_ff <= 10'h000;
            step_ff <= 1'b0;
        end else begin
            tclk_q_ff <= timing_clk;
            step_ff <= (timing_clk && !tclk_q_ff) || wr_sync;
            if (wr_sync) begin
                cnt_ff <= 10'h000;
            end else if (timing_clk && !tclk_q_ff) begin
                cnt_ff <= cnt_ff + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control words and duplicated on bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_ff <= '0;
            shared_duty_select_ff <= '0;
            shared_duty_ff <= `DUTY_EMPTY;
            for (int i = 0; i < NCH; i++) begin
                phase_select_ff[i] <= 2'h0;
                divider_select_ff[i] <= 2'h0;
                duty_value_ff[i] <= `DUTY_EMPTY;
            end
            for (int i = 0; i < 4; i++) begin
                pin_mode_ff[i] <= 2'h0;
            end
        end else if (reg_wr) begin
            if (wr_ch) begin
                for (int i = 0; i < NCH; i++) begin
                    if (reg_in.addr == 4'(i + 2)) begin
                        duty_value_ff[i] <= reg_in.data[7:0];
                        on_ff[i] <= reg_in.data[`BIT_ON];
                        phase_select_ff[i] <= reg_in.data[10:9];
                    end
                end
            end
            if (reg_in.addr == `ADDR_OUT_CTRL) begin
                on_ff <= reg_in.data[NCH-1:0];
            end
            if (reg_in.addr == `ADDR_GLOBAL) begin
                if (reg_in.data[`BIT_SUBREG]) begin
                    shared_duty_ff <= reg_in.data[7:0];
                end else begin
                    shared_duty_select_ff <= reg_in.data[NCH-1:0];
                end
            end
            if (reg_in.addr == `ADDR_PIN_MODE) begin
                for (int i = 0; i < 4; i++) begin
                    pin_mode_ff[i] <= reg_in.data[2*i +: 2];
                end
            end
            if (reg_in.addr == `ADDR_DIVIDER) begin
                for (int i = 0; i < 3; i++) begin
                    if (reg_in.data[`BIT_SUBREG]) begin
                        divider_select_ff[i+3] <= reg_in.data[2*i +: 2];
                    end else begin
                        divider_select_ff[i] <= reg_in.data[2*i +: 2];
                    end
                end
            end
            if (wr_step) begin
                for (int i = 0; i < 5; i++) begin
                    duty_value_ff[i] <= step_duty(duty_value_ff[i], reg_in.data[2*i +: 2],
                        reg_in.data[`BIT_STEP_DIR]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel state and duty source; external channels have no pin
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic [1:0] md;
            logic pin;
            md = (i < 4) ? pin_mode_ff[i] : 2'h0;
            pin = (i < 4) ? control_input_pin[i] : 1'b0;
            channel_state[i] = on_ff[i] && ((md == 2'h0) || (md == 2'h3) || pin);
            tgt[i] = ((shared_duty_select_ff[i] ^ (md == 2'h3 && pin)) ? shared_duty_ff
                : duty_value_ff[i]);
            pos[i] = ch_pos(cnt_ff, divider_select_ff[i], phase_select_ff[i]);
            pstart[i] = step_ff && pos[i] == `DUTY_EMPTY
                && (divider_select_ff[i][1] || (divider_select_ff[i][0] ? !cnt_ff[0]
                : cnt_ff[1:0] == 2'h0));
            lit[i] = run_ff[i] && pos[i] <= act_duty_ff[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // full duty and off act at once, anything else waits for period start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                act_duty_ff[i] <= `DUTY_EMPTY;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!channel_state[i]) begin
                    run_ff[i] <= 1'b0;
                end else if (tgt[i] == `DUTY_FULL) begin
                    run_ff[i] <= 1'b1;
                    act_duty_ff[i] <= tgt[i];
                end else if (pstart[i]) begin
                    run_ff[i] <= 1'b1;
                    act_duty_ff[i] <= tgt[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        if (fail_mode) begin
            nxt_drive = {2'b00, control_input_pin};
        end else if (clk_fail) begin
            nxt_drive = channel_state;
        end else begin
            nxt_drive = lit;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_drive_ff <= '0;
            state_q_ff <= '0;
            window_start_ff <= '0;
        end else begin
            channel_drive_ff <= nxt_drive;
            state_q_ff <= channel_state;
            window_start_ff <= channel_state & ~state_q_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_fail_full: assert property (clk_fail && !fail_mode |=>
        channel_drive_ff == $past(channel_state)) else $error("clock fail not full duty");
    a_failmode_off: assert property (fail_mode |=>
        channel_drive_ff[5:4] == 2'b00) else $error("fail mode drove outer channels");
    // fail mode hands the drive to the pins, so it is excused here
    a_off_now: assert property (!channel_state[0] && !fail_mode |=> !run_ff[0]
        ##1 !channel_drive_ff[0] || $past(channel_state[0]) || $past(fail_mode))
        else $error("off not immediate");
    a_full_now: assert property (channel_state[0] && tgt[0] == `DUTY_FULL |=>
        run_ff[0] && act_duty_ff[0] == `DUTY_FULL) else $error("full duty delayed");
    a_below_wait: assert property ($rose(run_ff[0]) && act_duty_ff[0] != `DUTY_FULL
        |-> $past(pstart[0])) else $error("partial duty before period start");
    a_sync_cnt: assert property (wr_sync |=> cnt_ff == 10'h000 && step_ff)
        else $error("sync did not clear counter");
    a_on_copy: assert property (reg_wr && reg_in.addr == `ADDR_OUT_CTRL |=>
        on_ff == $past(reg_in.data[NCH-1:0])) else $error("on bits not mirrored");
    a_step_sat: assert property (wr_step && reg_in.data[`BIT_STEP_DIR]
        && reg_in.data[3:2] == 2'h3 && duty_value_ff[1] >= 8'hf0
        |=> duty_value_ff[1] == `DUTY_FULL) else $error("step up did not saturate");
    a_step_ext: assert property (wr_step |=> $stable(duty_value_ff[5])
        && $stable(shared_duty_ff)) else $error("step touched external or shared duty");
    a_window: assert property ($rose(channel_state[1]) |=> window_start_ff[1]
        ##1 !window_start_ff[1]) else $error("window start not a single pulse");

    ////////////////////////////////////////////////////////////////////////////
    // control word fields land in their own channel only
    a_duty_store: assert property (reg_wr && reg_in.addr == `ADDR_CH_FIRST
        |=> duty_value_ff[0] == $past(reg_in.data[7:0]))
        else $error("duty field not stored");

    a_phase_store: assert property (reg_wr && reg_in.addr == `ADDR_CH_FIRST
        |=> phase_select_ff[0] == $past(reg_in.data[10:9]))
        else $error("phase field not stored");

    a_div_store: assert property (reg_wr && reg_in.addr == `ADDR_DIVIDER
        && !reg_in.data[`BIT_SUBREG] |=> divider_select_ff[1] == $past(reg_in.data[3:2]))
        else $error("divider field not stored");

    // shared value write must leave the select bits alone
    a_shared_reg: assert property (reg_wr && reg_in.addr == `ADDR_GLOBAL
        && reg_in.data[`BIT_SUBREG] |=> shared_duty_ff == $past(reg_in.data[7:0])
        && $stable(shared_duty_select_ff)) else $error("shared duty not stored apart");

    a_shared_pick: assert property (shared_duty_select_ff[1]
        && pin_mode_ff[1] != 2'h3 |-> tgt[1] == shared_duty_ff)
        else $error("select bit did not pick shared duty");

    // mode 11 with the pin high swaps the source back to the own value
    a_pin_swap: assert property (shared_duty_select_ff[1] && pin_mode_ff[1] == 2'h3
        && control_input_pin[1] |-> tgt[1] == duty_value_ff[1])
        else $error("pin did not swap duty source");

    a_pin_gate: assert property (on_ff[1] && pin_mode_ff[1] == 2'h1
        && !control_input_pin[1] |-> !channel_state[1])
        else $error("pin low did not gate channel");

    a_off_bit: assert property (!on_ff[1] |-> !channel_state[1])
        else $error("cleared on bit left channel on");

    // a plain step must move by exactly the coded amount
    a_step_down: assert property (wr_step && !reg_in.data[`BIT_STEP_DIR]
        && reg_in.data[3:2] == 2'h3 && duty_value_ff[1] >= 8'h10
        |=> duty_value_ff[1] == $past(duty_value_ff[1]) - 8'h10) else $error("step down wrong");

    a_cnt_step: assert property (!wr_sync && timing_clk && !tclk_q_ff
        |=> cnt_ff == $past(cnt_ff) + 10'h001)
        else $error("counter missed a timing edge");

    a_lit_full: assert property (run_ff[0] && act_duty_ff[0] == `DUTY_FULL
        |-> lit[0]) else $error("full duty not continuous");

    a_pin_drive: assert property (fail_mode
        |=> channel_drive_ff[3:0] == $past(control_input_pin))
        else $error("fail mode drive not from pins");

    a_win_rise: assert property (window_start_ff[0]
        |-> $past(channel_state[0]) && !$past(channel_state[0], 2))
        else $error("window start without rising state");

    c_sync: cover property (wr_sync ##[1:20] pstart[0]);
    c_fail: cover property (clk_fail ##1 channel_drive_ff[1]);
    c_shared: cover property (shared_duty_select_ff[1] && run_ff[1]);
    c_step: cover property (wr_step ##1 run_ff[0]);
    c_pin_gate: cover property (channel_state[0] ##1 !channel_state[0] && on_ff[0]);
endmodule : lamp_pwm_ctrl

// File: tb/lamp_host_model.sv
`timescale 1ns/1ps
module lamp_host_model (
    input wire logic clk, // system clock
    output logic reg_wr, // frame applied pulse
    output lamp_pwm_pkg::reg_wr_t reg_in // frame address and data
);
    initial begin
        reg_wr = 1'b0;
        reg_in = '0;
    end
    // one frame per call; callers switch a channel off before phase or divider
    // changes and keep duty codes inside the usable band
    task automatic write_frame(input logic [3:0] addr, input logic [11:0] data);
        @(negedge clk);
        reg_in = {addr, data};
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // stale frame must not look valid
        reg_in = ~reg_in;
    endtask : write_frame
endmodule : lamp_host_model

// File: tb/test_multichannel_lamp_pwm_control.sv
`timescale 1ns/1ps
module test_multichannel_lamp_pwm_control;
    logic clk, rstn, timing_clk, clk_fail, fail_mode, reg_wr;
    logic [3:0] control_input_pin;
    logic [2:0] tdiv;
    lamp_pwm_pkg::reg_wr_t reg_in;
    logic [5:0] channel_drive_ff, window_start_ff, channel_state;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    lamp_host_model lamp_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_in(reg_in));
    lamp_pwm_ctrl #(.NCH(6)) lamp_pwm_ctrl_inst (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_in(reg_in), .timing_clk(timing_clk), .clk_fail(clk_fail), .fail_mode(fail_mode),
        .control_input_pin(control_input_pin), .channel_drive_ff(channel_drive_ff),
        .window_start_ff(window_start_ff), .channel_state(channel_state));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // timing clock four times slower than clk keeps a period at 1024 clk for /1
    always @(negedge clk) begin
        tdiv <= tdiv + 3'h1;
        timing_clk <= tdiv[1];
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic measure(input int ch, input int n, output int on);
        on = 0;
        repeat (n) begin
            @(negedge clk);
            if (channel_drive_ff[ch] === 1'b1) on++;
        end
    endtask : measure
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        lamp_host_model_inst.write_frame(a, d);
    endtask : wr
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int cnt;
        int dv;
        logic [11:0] sd [4] = '{12'h13f, 12'h1f7, 12'h1f7, 12'h13f};
        logic [11:0] sc [4] = '{12'h404, 12'h40c, 12'h00c, 12'h408};
        int se [4] = '{272, 1024, 928, 288};
        logic [11:0] pm [3] = '{12'h004, 12'h008, 12'h00c};
        rstn = 1'b0;
        clk_fail = 1'b0;
        fail_mode = 1'b0;
        control_input_pin = 4'h0;
        tdiv = 3'h0;
        timing_clk = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        check(channel_state, 6'h00);
        check(channel_drive_ff, 6'h00);
        wr(4'h2, 12'h1ff);
        check(channel_state, 6'h01);
        @(negedge clk);
        check(window_start_ff, 6'h01);
        @(negedge clk);
        check({window_start_ff, channel_drive_ff}, 12'h001);
        wr(4'h8, 12'h000);
        check(channel_state, 6'h00);
        repeat (2) @(negedge clk);
        check(channel_drive_ff, 6'h00);
        wr(4'h1, 12'h002);
        // codes 00, 01, 10, 11 give /4, /2, /1, /1
        for (int i = 0; i < 4; i++) begin
            dv = (i == 0) ? 4 : (i == 1) ? 2 : 1;
            wr(4'h3, 12'h03f);
            wr(4'hc, 12'(i << 2));
            wr(4'h3, 12'h13f);
            measure(1, 1024 * dv, cnt);
            measure(1, 1024 * dv, cnt);
            check(cnt, 256 * dv);
        end
        // up 4, up 16 into the rail, down 16, up 8
        for (int i = 0; i < 4; i++) begin
            wr(4'h3, sd[i]);
            wr(4'he, sc[i]);
            measure(1, 1024, cnt);
            measure(1, 1024, cnt);
            check(cnt, se[i]);
        end
        wr(4'h9, 12'h17f);
        wr(4'h9, 12'h002);
        measure(1, 1024, cnt);
        measure(1, 1024, cnt);
        check(cnt, 512);
        for (int i = 0; i < 3; i++) begin
            wr(4'hb, pm[i]);
            control_input_pin = 4'h0;
            @(negedge clk);
            check(channel_state[1], (i == 2) ? 1'b1 : 1'b0);
            control_input_pin = 4'h2;
            @(negedge clk);
            check(channel_state[1], 1'b1);
        end
        wr(4'hb, 12'h000);
        clk_fail = 1'b1;
        repeat (3) @(negedge clk);
        check(channel_drive_ff, 6'h02);
        fail_mode = 1'b1;
        control_input_pin = 4'h5;
        repeat (3) @(negedge clk);
        check(channel_drive_ff, 6'h05);
        finish_test();
    end
endmodule : test_multichannel_lamp_pwm_control
